// >>> display_host_map.svh
`ifndef DISPLAY_HOST_MAP_SVH
`define DISPLAY_HOST_MAP_SVH

// ****************************************************************
// Address counter limits
// ****************************************************************
`define CHAR_FIRST 7'h00
`define CHAR_LINE0_END 7'h27
`define CHAR_LINE1_START 7'h40
`define CHAR_LINE1_END 7'h67
`define CHAR_STEP 7'h01
`define GLYPH_STEP 6'h01
`define AC_RESET 7'h00
`define DIR_RESET 1'h1
`define BUSY_FLAG 1'h0

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define HDR_ONES 5'h1F
`define HDR_RNW_BIT 2
`define HDR_RS_BIT 1
`define HDR_TAIL_BIT 0
`define SER_HDR_LAST 5'h07
`define SER_BYTE_LAST 5'h0F
`define SER_BITS 5'h10
`define SER_RD_PHASE 2'h1

// ****************************************************************
// Instruction codes that move the address counter or set its step direction
// ****************************************************************
`define INSTR_CLEAR 8'h01
`define INSTR_HOME_TOP 7'h01
`define INSTR_ENTRY_TOP 6'h01
`define INSTR_GLYPH_ADDR_TOP 2'h1

// ****************************************************************
// Strap capture
// ****************************************************************
`define STRAP_LATCH_CYCLE 2'h2

`endif

// >>> display_host_pkg.sv
package display_host_pkg;

	typedef enum logic [1:0] {
		MODE_ENABLE_STROBE = 2'b00,
		MODE_SEPARATE_STROBE = 2'b01,
		MODE_SERIAL = 2'b10,
		MODE_UNUSED = 2'b11
	} host_mode_t;

	typedef enum logic {
		NIB_UPPER = 1'b0,
		NIB_LOWER = 1'b1
	} nib_phase_t;

endpackage

// >>> display_host_interface.sv
// Operation
// - Interface type comes from straps latched after reset, never from commands.
// - Parallel bytes move whole in 8-bit mode or as two halves in 4-bit mode.
// - 4-bit mode: upper half first, both on DB7..DB4; DB3..DB0 ignored.
// - Parallel register select low means instruction, high means data.
// - Enable-strobe mode writes on falling enable while read_not_write is low.
// - Enable-strobe mode drives read data after rising enable with read_not_write high.
// - Separate-strobe mode writes on rising write strobe.
// - Separate-strobe mode drives read data after falling read strobe.
// - Serial transaction is two bytes, most significant bit first.
// - Serial direction bit one means read, zero means write.
// - Serial register select zero means instruction, one means data.
// - Serial write samples the line on every rising serial clock.
// - Serial read samples header on rising edges, returns bits after falling edges.
// - Frame opens on falling frame select; unclosed frames are discarded.
// - Power-up reset always; external reset only in parallel modes when strapped.
// - Character memory increment steps by one, 27H to 40H, 67H to 00H.
// - Character memory decrement steps by one, 40H to 27H, 00H to 67H.
// - Glyph memory steps by one, wrapping between 3FH and 00H.
// - Address counter in character memory is the cursor position.
// - Busy indicator always reads zero.
// - Step direction one increments, zero decrements, after each memory access.
`timescale 1ns/1ps
`include "display_host_map.svh"

module display_host_interface (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [1:0] MODE_STRAP,
	input wire logic BUS_WIDE_STRAP,
	input wire logic EXT_RESET_STRAP,
	input wire logic RESET_IN_N,
	input wire logic REG_SELECT_LINE,
	input wire logic READ_NOT_WRITE,
	input wire logic BUS_STROBING,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic [7:0] DB_IN,
	output logic [7:0] DB_OUT,
	output logic DB_OE,
	input wire logic SERIAL_CLK,
	input wire logic FRAME_SELECT_N,
	input wire logic SERIAL_IO_IN,
	output logic SERIAL_IO_OUT,
	output logic SERIAL_IO_OE,
	output display_host_pkg::host_mode_t ACTIVE_MODE,
	output logic [6:0] CURSOR_POS,
	output logic CURSOR_VALID,
	output logic STEP_DIRECTION,
	output logic INSTR_VALID,
	output logic [7:0] INSTR_BYTE
);
	import display_host_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [18:0] pin_meta;
	logic [18:0] pin_sync;
	logic rst_in_n_s;
	logic frame_s;
	logic rs_s;
	logic rnw_s;
	logic e_s;
	logic wr_n_s;
	logic rd_n_s;
	logic [1:0] mode_s;
	logic wide_s;
	logic ext_rst_s;
	logic [7:0] db_s;

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= {RESET_IN_N, FRAME_SELECT_N, REG_SELECT_LINE, READ_NOT_WRITE,
				BUS_STROBING, WRITE_STROBE_N, READ_STROBE_N, MODE_STRAP,
				BUS_WIDE_STRAP, EXT_RESET_STRAP, DB_IN};
			pin_sync <= pin_meta;
		end
	end

	assign {rst_in_n_s, frame_s, rs_s, rnw_s, e_s, wr_n_s, rd_n_s, mode_s,
		wide_s, ext_rst_s, db_s} = pin_sync;

	// ****************************************************************
	// Straps and reset
	// ****************************************************************
	logic [1:0] strap_cnt;
	logic ready;
	logic wide;
	logic ext_rst_en;
	logic soft_rst;
	logic live;

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			strap_cnt <= '0;
			ready <= 1'b0;
			ACTIVE_MODE <= MODE_ENABLE_STROBE;
			wide <= 1'b1;
			ext_rst_en <= 1'b0;
		end
		else if (!ready)
		begin
			strap_cnt <= strap_cnt + 2'h1;
			// Straps are taken once; later strap changes have no effect
			if (strap_cnt == `STRAP_LATCH_CYCLE)
			begin
				ACTIVE_MODE <= host_mode_t'(mode_s);
				wide <= wide_s;
				ext_rst_en <= ext_rst_s;
				ready <= 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
			soft_rst <= 1'b0;
		else
			soft_rst <= ready && ext_rst_en && (ACTIVE_MODE != MODE_SERIAL) && !rst_in_n_s;
	end

	assign live = ready && !soft_rst;

	// ****************************************************************
	// Edge detection on synchronised strobes
	// ****************************************************************
	logic e_q;
	logic wr_n_q;
	logic rd_n_q;
	logic frame_q;

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			e_q <= 1'b0;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			frame_q <= 1'b1;
		end
		else
		begin
			e_q <= e_s;
			wr_n_q <= wr_n_s;
			rd_n_q <= rd_n_s;
			frame_q <= frame_s;
		end
	end

	logic par_wr_strobe;
	logic par_rd_start;
	logic par_rd_end;

	always_comb
	begin
		par_wr_strobe = 1'b0;
		par_rd_start = 1'b0;
		par_rd_end = 1'b0;
		case (ACTIVE_MODE)
			MODE_ENABLE_STROBE:
			begin
				par_wr_strobe = live && e_q && !e_s && !rnw_s;
				par_rd_start = live && !e_q && e_s && rnw_s;
				par_rd_end = live && e_q && !e_s && rnw_s;
			end
			MODE_SEPARATE_STROBE:
			begin
				par_wr_strobe = live && !wr_n_q && wr_n_s;
				par_rd_start = live && rd_n_q && !rd_n_s;
				par_rd_end = live && !rd_n_q && rd_n_s;
			end
			default:
			begin
				par_wr_strobe = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Address counter state and memories
	// ****************************************************************
	logic [6:0] ac;
	logic ac_glyph;
	logic dir_up;
	logic [7:0] char_code_mem [0:127];
	logic [7:0] glyph_mem [0:63];

	function automatic logic [7:0] read_value(input logic data_sel);
		logic [7:0] mem_word;
		mem_word = ac_glyph ? glyph_mem[ac[5:0]] : char_code_mem[ac];
		return data_sel ? mem_word : {`BUSY_FLAG, ac};
	endfunction

	function automatic logic [6:0] stepped(input logic [6:0] a, input logic glyph,
		input logic up);
		logic [6:0] r;
		r = a;
		if (glyph)
			r = {1'b0, up ? a[5:0] + `GLYPH_STEP : a[5:0] - `GLYPH_STEP};
		else if (up)
		begin
			if (a == `CHAR_LINE0_END)
				r = `CHAR_LINE1_START;
			else if (a == `CHAR_LINE1_END)
				r = `CHAR_FIRST;
			else
				r = a + `CHAR_STEP;
		end
		else
		begin
			if (a == `CHAR_LINE1_START)
				r = `CHAR_LINE0_END;
			else if (a == `CHAR_FIRST)
				r = `CHAR_LINE1_END;
			else
				r = a - `CHAR_STEP;
		end
		return r;
	endfunction

	// ****************************************************************
	// Parallel port: half-byte tracker and read drive
	// ****************************************************************
	nib_phase_t nib_phase;
	logic [3:0] nib_hi;
	logic [7:0] rd_latch;
	logic par_wr_done;
	logic [7:0] par_wr_byte;
	logic par_rd_step;
	logic [7:0] par_value;

	assign par_wr_done = par_wr_strobe && (wide || nib_phase == NIB_LOWER);
	assign par_wr_byte = wide ? db_s : {nib_hi, db_s[7:4]};
	assign par_rd_step = par_rd_end && rs_s && (wide || nib_phase == NIB_LOWER);
	// A process, not an assign, so that memory and counter changes also refresh the value
	always_comb
	begin
		par_value = read_value(rs_s);
	end

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			nib_phase <= NIB_UPPER;
			nib_hi <= 4'h0;
		end
		else if (soft_rst)
			nib_phase <= NIB_UPPER;
		else if ((par_wr_strobe || par_rd_end) && !wide)
		begin
			// Reads and writes share one tracker, as on a single bus
			if (nib_phase == NIB_UPPER)
			begin
				nib_phase <= NIB_LOWER;
				nib_hi <= db_s[7:4];
			end
			else
				nib_phase <= NIB_UPPER;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			DB_OUT <= 8'h00;
			DB_OE <= 1'b0;
			rd_latch <= 8'h00;
		end
		else if (soft_rst)
			DB_OE <= 1'b0;
		else if (par_rd_start)
		begin
			DB_OE <= 1'b1;
			if (wide)
			begin
				rd_latch <= par_value;
				DB_OUT <= par_value;
			end
			else if (nib_phase == NIB_UPPER)
			begin
				// The whole byte is frozen so both halves come from one read
				rd_latch <= par_value;
				DB_OUT <= {par_value[7:4], 4'h0};
			end
			else
				DB_OUT <= {rd_latch[3:0], 4'h0};
		end
		else if (par_rd_end)
			DB_OE <= 1'b0;
	end

	// ****************************************************************
	// Serial link domain
	// ****************************************************************
	logic [4:0] lnk_cnt;
	logic [7:0] lnk_shift;
	logic [7:0] lnk_hdr;
	logic [7:0] lnk_next;
	logic [15:0] lnk_word;
	logic lnk_hdr_tgl;
	logic lnk_done_tgl;
	logic [7:0] ser_rd_byte;

	assign lnk_next = {lnk_shift[6:0], SERIAL_IO_IN};

	// Frame select high holds the bit counter idle, so a new frame always starts at bit 0
	always_ff @(posedge SERIAL_CLK or posedge FRAME_SELECT_N or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lnk_cnt <= 5'h00;
			lnk_shift <= 8'h00;
			lnk_hdr <= 8'h00;
		end
		else if (FRAME_SELECT_N)
		begin
			lnk_cnt <= 5'h00;
			lnk_shift <= 8'h00;
			lnk_hdr <= 8'h00;
		end
		else
		begin
			lnk_shift <= lnk_next;
			if (lnk_cnt != `SER_BITS)
				lnk_cnt <= lnk_cnt + 5'h01;
			if (lnk_cnt == `SER_HDR_LAST)
				lnk_hdr <= lnk_next;
		end
	end

	always_ff @(posedge SERIAL_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lnk_hdr_tgl <= 1'b0;
			lnk_done_tgl <= 1'b0;
			lnk_word <= 16'h0000;
		end
		else
		begin
			if (lnk_cnt == `SER_HDR_LAST && lnk_next[`HDR_RNW_BIT])
				lnk_hdr_tgl <= !lnk_hdr_tgl;
			if (lnk_cnt == `SER_BYTE_LAST)
			begin
				lnk_word <= {lnk_hdr, lnk_next};
				lnk_done_tgl <= !lnk_done_tgl;
			end
		end
	end

	// Read byte is quasi-static: it settles well inside the host's wait gap
	always_ff @(negedge SERIAL_CLK or posedge FRAME_SELECT_N or negedge RSTN)
	begin
		if (!RSTN)
		begin
			SERIAL_IO_OUT <= 1'b0;
			SERIAL_IO_OE <= 1'b0;
		end
		else if (FRAME_SELECT_N)
			SERIAL_IO_OE <= 1'b0;
		// The strapped mode is static here, so reading it from this domain is safe
		else if (ACTIVE_MODE == MODE_SERIAL && lnk_hdr[`HDR_RNW_BIT]
			&& lnk_cnt[4:3] == `SER_RD_PHASE)
		begin
			SERIAL_IO_OE <= 1'b1;
			SERIAL_IO_OUT <= ser_rd_byte[~lnk_cnt[2:0]];
		end
	end

	// ****************************************************************
	// Serial events into the reference domain
	// ****************************************************************
	logic [2:0] hdr_sync;
	logic [2:0] done_sync;
	logic hdr_edge;
	logic done_edge;
	logic ser_pending;
	logic frame_rise;
	logic frame_fall;
	logic [7:0] ser_hdr;
	logic ser_hdr_ok;
	logic ser_commit;
	logic ser_wr;
	logic ser_rd_step;

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			hdr_sync <= 3'h0;
			done_sync <= 3'h0;
		end
		else
		begin
			hdr_sync <= {hdr_sync[1:0], lnk_hdr_tgl};
			done_sync <= {done_sync[1:0], lnk_done_tgl};
		end
	end

	assign hdr_edge = hdr_sync[2] ^ hdr_sync[1];
	assign done_edge = done_sync[2] ^ done_sync[1];
	assign frame_rise = !frame_q && frame_s;
	assign frame_fall = frame_q && !frame_s;
	assign ser_hdr = lnk_word[15:8];
	assign ser_hdr_ok = ser_hdr[7:3] == `HDR_ONES && !ser_hdr[`HDR_TAIL_BIT];
	assign ser_commit = live && ACTIVE_MODE == MODE_SERIAL && frame_rise
		&& (ser_pending || done_edge) && ser_hdr_ok;
	assign ser_wr = ser_commit && !ser_hdr[`HDR_RNW_BIT];
	assign ser_rd_step = ser_commit && ser_hdr[`HDR_RNW_BIT] && ser_hdr[`HDR_RS_BIT];

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
			ser_pending <= 1'b0;
		else if (done_edge)
			ser_pending <= 1'b1;
		else if (frame_rise || frame_fall)
			ser_pending <= 1'b0;
	end

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
			ser_rd_byte <= 8'h00;
		else if (hdr_edge)
			ser_rd_byte <= read_value(lnk_hdr[`HDR_RS_BIT]);
	end

	// ****************************************************************
	// Byte application and address counter
	// ****************************************************************
	logic ev_wr;
	logic ev_data;
	logic [7:0] ev_byte;
	logic ev_rd_step;

	assign ev_wr = par_wr_done || ser_wr;
	assign ev_data = ser_wr ? ser_hdr[`HDR_RS_BIT] : rs_s;
	assign ev_byte = ser_wr ? lnk_word[7:0] : par_wr_byte;
	assign ev_rd_step = par_rd_step || ser_rd_step;

	always_ff @(posedge REF_CLK)
	begin
		if (live && ev_wr && ev_data)
		begin
			if (ac_glyph)
				glyph_mem[ac[5:0]] <= ev_byte;
			else
				char_code_mem[ac] <= ev_byte;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ac <= `AC_RESET;
			ac_glyph <= 1'b0;
			dir_up <= `DIR_RESET;
		end
		else if (soft_rst)
		begin
			ac <= `AC_RESET;
			ac_glyph <= 1'b0;
			dir_up <= `DIR_RESET;
		end
		else if ((ev_wr && ev_data) || ev_rd_step)
			ac <= stepped(ac, ac_glyph, dir_up);
		else if (ev_wr)
		begin
			if (ev_byte[7])
			begin
				ac <= ev_byte[6:0];
				ac_glyph <= 1'b0;
			end
			else if (ev_byte[7:6] == `INSTR_GLYPH_ADDR_TOP)
			begin
				ac <= {1'b0, ev_byte[5:0]};
				ac_glyph <= 1'b1;
			end
			else if (ev_byte[7:1] == `INSTR_HOME_TOP)
			begin
				ac <= `AC_RESET;
				ac_glyph <= 1'b0;
			end
			else if (ev_byte == `INSTR_CLEAR)
			begin
				ac <= `AC_RESET;
				ac_glyph <= 1'b0;
				dir_up <= `DIR_RESET;
			end
			else if (ev_byte[7:2] == `INSTR_ENTRY_TOP)
				dir_up <= ev_byte[1];
		end
	end

	// ****************************************************************
	// Status outputs
	// ****************************************************************
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			CURSOR_POS <= `AC_RESET;
			CURSOR_VALID <= 1'b0;
			STEP_DIRECTION <= `DIR_RESET;
			INSTR_VALID <= 1'b0;
			INSTR_BYTE <= 8'h00;
		end
		else
		begin
			CURSOR_POS <= ac;
			CURSOR_VALID <= !ac_glyph;
			STEP_DIRECTION <= dir_up;
			INSTR_VALID <= live && ev_wr && !ev_data;
			if (live && ev_wr && !ev_data)
				INSTR_BYTE <= ev_byte;
		end
	end

endmodule // display_host_interface

// >>> host_port_chk.sv
`timescale 1ns/1ps
module host_port_chk (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic BUS_WIDE_STRAP,
	input wire logic REG_SELECT_LINE,
	input wire logic READ_NOT_WRITE,
	input wire logic BUS_STROBING,
	input wire logic READ_STROBE_N,
	input wire logic FRAME_SELECT_N,
	input wire logic [7:0] DB_OUT,
	input wire logic DB_OE,
	input wire logic SERIAL_IO_OE,
	input wire display_host_pkg::host_mode_t ACTIVE_MODE,
	input wire logic [6:0] CURSOR_POS,
	input wire logic CURSOR_VALID,
	input wire logic STEP_DIRECTION,
	input wire logic INSTR_VALID
);
	import display_host_pkg::*;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);

	// ****************************************
	// Strobe steps
	// ****************************************
	sequence e_read_start;
		$rose(BUS_STROBING) && READ_NOT_WRITE;
	endsequence

	sequence e_instr_write;
		$fell(BUS_STROBING) && !READ_NOT_WRITE && !REG_SELECT_LINE;
	endsequence

	// ****************************************
	// Checks
	// ****************************************
	chk_enable_read: assert property (
		(ACTIVE_MODE == MODE_ENABLE_STROBE) ##0 e_read_start |-> ##[1:5] DB_OE)
		else $error("enable read not answered");
	chk_split_read: assert property (
		(ACTIVE_MODE == MODE_SEPARATE_STROBE) ##0 $fell(READ_STROBE_N) |-> ##[1:5] DB_OE)
		else $error("read strobe not answered");
	chk_enable_write: assert property (
		(ACTIVE_MODE == MODE_ENABLE_STROBE && BUS_WIDE_STRAP) ##0 e_instr_write
		|-> ##[1:6] INSTR_VALID)
		else $error("instruction write not taken");
	chk_write_quiet: assert property (
		(ACTIVE_MODE == MODE_ENABLE_STROBE && !READ_NOT_WRITE) [*8] |-> !DB_OE)
		else $error("bus driven during write");
	chk_busy_zero: assert property (
		DB_OE && BUS_WIDE_STRAP && !REG_SELECT_LINE |-> !DB_OUT[7])
		else $error("busy bit set");
	chk_frame_oe: assert property (
		FRAME_SELECT_N && $past(FRAME_SELECT_N) |-> !SERIAL_IO_OE)
		else $error("serial line driven outside frame");
	chk_mode_oe: assert property (ACTIVE_MODE == MODE_SERIAL ? !DB_OE : !SERIAL_IO_OE)
		else $error("wrong interface drives");
	chk_instr_pulse: assert property (INSTR_VALID |=> !INSTR_VALID)
		else $error("instruction pulse too long");
	// The cursor lags the instruction pulse by one cycle, so the pulse is looked at one back
	chk_up_wrap: assert property ($changed(CURSOR_POS) && $past(CURSOR_POS) == 7'h27
		&& STEP_DIRECTION && CURSOR_VALID && !$past(INSTR_VALID) |-> CURSOR_POS == 7'h40)
		else $error("increment wrap wrong");
	chk_down_wrap: assert property ($changed(CURSOR_POS) && !STEP_DIRECTION
		&& CURSOR_VALID && !$past(INSTR_VALID)
		&& ($past(CURSOR_POS) == 7'h40 || $past(CURSOR_POS) == 7'h00)
		|-> CURSOR_POS == ($past(CURSOR_POS) == 7'h40 ? 7'h27 : 7'h67))
		else $error("decrement wrap wrong");
endmodule // host_port_chk

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic [1:0] mode,
	input wire logic [7:0] db,
	input wire logic sio,
	output logic rs,
	output logic rnw,
	output logic e,
	output logic wr_n,
	output logic rd_n,
	output logic [7:0] hdb,
	output logic hdb_oe,
	output logic sck,
	output logic fs_n,
	output logic hsi,
	output logic hsi_oe
);
	import display_host_pkg::*;

	initial
	begin
		{rs, rnw, e, hdb_oe, hsi_oe, hdb} = 13'h0;
		{wr_n, rd_n, sck, fs_n, hsi} = 5'h1F;
	end

	// ****************************************
	// Parallel cycle, one byte or one half
	// ****************************************
	// Phases of 4, 12, 8 and 12 cycles keep every strobe width legal
	task automatic cycle(input logic r, input logic s, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		rs <= s;
		rnw <= r;
		hdb <= d;
		hdb_oe <= !r;
		repeat (4) @(posedge clk);
		e <= mode == MODE_ENABLE_STROBE;
		wr_n <= !(mode == MODE_SEPARATE_STROBE && !r);
		rd_n <= !(mode == MODE_SEPARATE_STROBE && r);
		repeat (12) @(posedge clk);
		q = db;
		e <= 1'b0;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (8) @(posedge clk);
		hdb_oe <= 1'b0;
		rnw <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	// ****************************************
	// Serial frame
	// ****************************************
	// Clock idles high and stands still between frames
	task automatic ser(input logic [15:0] f, input int n, output logic [7:0] q);
		@(posedge clk);
		#7;
		fs_n = 1'b0;
		hsi_oe = 1'b1;
		#100;
		for (int i = 0; i < n; i++)
		begin
			if (i == 8 && f[10])
			begin
				hsi_oe = 1'b0;
				#1000;
			end
			sck = 1'b0;
			hsi = f[15 - i];
			#3;
			if (i > 7)
				q[15 - i] = sio;
			sck = 1'b1;
			#3;
		end
		#500;
		fs_n = 1'b1;
		hsi_oe = 1'b0;
		#600;
	endtask
endmodule // host_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import display_host_pkg::*;

	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	host_mode_t mode_strap = MODE_ENABLE_STROBE;
	logic wide = 1'b1;
	logic reset_in_n = 1'b1;
	logic ext_strap = 1'b0;
	logic rs, rnw, e, wr_n, rd_n, hdb_oe, sck, fs_n, hsi, hsi_oe;
	logic [7:0] hdb, db_out, instr_byte, q;
	logic db_oe, sio_out, sio_oe, cursor_valid, step_dir, instr_valid;
	logic [6:0] cursor_pos;
	host_mode_t active_mode;
	wire [7:0] db_line;
	wire sio_line;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Pull-ups win when nobody drives a line
	assign db_line = db_oe ? db_out : (hdb_oe ? hdb : 8'hFF);
	assign sio_line = sio_oe ? sio_out : (hsi_oe ? hsi : 1'b1);

	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end

	display_host_interface uut (
		.REF_CLK(ref_clk), .RSTN(rstn), .MODE_STRAP(mode_strap), .BUS_WIDE_STRAP(wide),
		.EXT_RESET_STRAP(ext_strap), .RESET_IN_N(reset_in_n), .REG_SELECT_LINE(rs),
		.READ_NOT_WRITE(rnw), .BUS_STROBING(e), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
		.DB_IN(db_line), .DB_OUT(db_out), .DB_OE(db_oe), .SERIAL_CLK(sck),
		.FRAME_SELECT_N(fs_n), .SERIAL_IO_IN(sio_line), .SERIAL_IO_OUT(sio_out),
		.SERIAL_IO_OE(sio_oe), .ACTIVE_MODE(active_mode), .CURSOR_POS(cursor_pos),
		.CURSOR_VALID(cursor_valid), .STEP_DIRECTION(step_dir), .INSTR_VALID(instr_valid),
		.INSTR_BYTE(instr_byte)
	);

	host_model host (
		.clk(ref_clk), .mode(mode_strap), .db(db_line), .sio(sio_line), .rs(rs), .rnw(rnw),
		.e(e), .wr_n(wr_n), .rd_n(rd_n), .hdb(hdb), .hdb_oe(hdb_oe), .sck(sck), .fs_n(fs_n),
		.hsi(hsi), .hsi_oe(hsi_oe)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic restart(input host_mode_t m, input logic w);
		@(posedge ref_clk);
		rstn <= 1'b0;
		mode_strap <= m;
		wide <= w;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (5000) @(posedge ref_clk);
		check({6'h00, active_mode}, {6'h00, m});
		check({step_dir, cursor_pos}, 8'h80);
	endtask

	// Narrow bus: garbage on the low lines must be ignored
	task automatic acc(input logic r, input logic s, input logic [7:0] d, output logic [7:0] v);
		logic [7:0] a;
		logic [7:0] b;
		if (wide)
			host.cycle(r, s, d, v);
		else
		begin
			host.cycle(r, s, {d[7:4], ~d[3:0]}, a);
			host.cycle(r, s, {d[3:0], d[7:4]}, b);
			v = {a[7:4], b[7:4]};
		end
	endtask

	task automatic step(input logic s, input logic [7:0] d, input logic [7:0] exp);
		acc(1'b0, s, d, q);
		check({1'b0, cursor_pos}, exp);
	endtask

	task automatic pulse_reset;
		@(posedge ref_clk);
		reset_in_n <= 1'b0;
		repeat (30) @(posedge ref_clk);
		reset_in_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		restart(MODE_ENABLE_STROBE, 1'b1);
		step(1'b0, 8'hA7, 8'h27);
		check(instr_byte, 8'hA7);
		step(1'b1, 8'h55, 8'h40);
		step(1'b0, 8'h04, 8'h40);
		check({7'h00, step_dir}, 8'h00);
		step(1'b1, 8'h55, 8'h27);
		acc(1'b1, 1'b0, 8'h00, q);
		check(q, 8'h27);
		acc(1'b1, 1'b1, 8'h00, q);
		check(q, 8'h55);
		check({1'b0, cursor_pos}, 8'h26);
		step(1'b0, 8'h80, 8'h00);
		step(1'b1, 8'h55, 8'h67);
		pulse_reset();
		check({1'b0, cursor_pos}, 8'h67);
		ext_strap <= 1'b1;
		$display("test enable strobe done");
		restart(MODE_SEPARATE_STROBE, 1'b0);
		step(1'b0, 8'hE7, 8'h67);
		check(instr_byte, 8'hE7);
		acc(1'b1, 1'b0, 8'h00, q);
		check(q, 8'h67);
		check({7'h00, cursor_valid}, 8'h01);
		step(1'b1, 8'h3C, 8'h00);
		step(1'b0, 8'h7F, 8'h3F);
		check({7'h00, cursor_valid}, 8'h00);
		step(1'b1, 8'h3C, 8'h00);
		step(1'b1, 8'h3C, 8'h01);
		host.cycle(1'b0, 1'b0, 8'hC0, q);
		pulse_reset();
		check({1'b0, cursor_pos}, 8'h00);
		repeat (5000) @(posedge ref_clk);
		step(1'b0, 8'hC5, 8'h45);
		$display("test separate strobe done");
		restart(MODE_SERIAL, 1'b1);
		host.ser({8'hF8, 8'hC5}, 16, q);
		check(instr_byte, 8'hC5);
		check({1'b0, cursor_pos}, 8'h45);
		pulse_reset();
		check({1'b0, cursor_pos}, 8'h45);
		host.ser({8'hFA, 8'h11}, 16, q);
		check({1'b0, cursor_pos}, 8'h46);
		host.ser({8'hFC, 8'h00}, 16, q);
		check(q, 8'h46);
		host.ser({8'hF8, 8'h80}, 12, q);
		check({1'b0, cursor_pos}, 8'h46);
		host.ser({8'hF8, 8'h04}, 16, q);
		check({7'h00, step_dir}, 8'h00);
		host.ser({8'hF8, 8'h01}, 16, q);
		check({step_dir, cursor_pos}, 8'h80);
		$display("test serial done");
		end_of_test();
	end

	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			failures++;
			end_of_test();
		end
	end
endmodule // tb

bind display_host_interface host_port_chk chk (.REF_CLK, .RSTN, .BUS_WIDE_STRAP, .REG_SELECT_LINE,
	.READ_NOT_WRITE, .BUS_STROBING, .READ_STROBE_N, .FRAME_SELECT_N, .DB_OUT, .DB_OE,
	.SERIAL_IO_OE, .ACTIVE_MODE, .CURSOR_POS, .CURSOR_VALID, .STEP_DIRECTION, .INSTR_VALID);
